// *** rtl/sfci_crc16.sv ***
// Bytewise CCITT check-value engine, one byte per clock
`include "sfci_regs.svh"
module sfci_crc16
  import sfci_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  sfci_crc_if.engine crc
);
  logic [15:0] remReg, remNext;
  logic [31:0] bufReg, bufNext;
  logic [2:0] cntReg, cntNext;

  //==============================================================
  // Byte step
  // byte then eight shifts
  function automatic logic [15:0] crcByte(input logic [15:0] rem, input logic [7:0] b);
    logic [15:0] r;
    r = rem ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `SFCI_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Loaded word drains top byte first; load is only given while idle
  always_comb begin
    remNext = remReg;
    bufNext = bufReg;
    cntNext = cntReg;
    if (crc.init) begin
      remNext = `SFCI_CRC_INIT;
      cntNext = 3'h0;
    end else if (crc.load) begin
      bufNext = crc.word;
      cntNext = crc.nBytes;
    end else if (cntReg != 3'h0) begin
      remNext = crcByte(remReg, bufReg[31:24]);
      bufNext = {bufReg[23:0], 8'h00};
      cntNext = cntReg - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      remReg <= `SFCI_CRC_INIT;
      bufReg <= 32'h00000000;
      cntReg <= 3'h0;
    end else begin
      remReg <= remNext;
      bufReg <= bufNext;
      cntReg <= cntNext;
    end
  end

  assign crc.busy = (cntReg != 3'h0);
  assign crc.value = remReg;
endmodule

// *** rtl/sfci_crc_if.sv ***
// Link between the sequencer and one check-value engine
interface sfci_crc_if;
  logic init;
  logic load;
  logic [31:0] word;
  logic [2:0] nBytes;
  logic busy;
  logic [15:0] value;
  modport ctrl (output init, load, word, nBytes, input busy, value);
  modport engine (input init, load, word, nBytes, output busy, value);
endinterface

// *** rtl/sfci_host.sv ***
// Host-side frame controller with check word and Hamming protection
`include "sfci_regs.svh"
module sfci_host
  import sfci_pkg::*;
#(
  parameter int MAX_WORDS = `SFCI_MAX_WORDS,
  parameter int SCLK_HALF = `SFCI_SCLK_HALF,
  parameter int RETRIES = `SFCI_RETRIES,
  localparam int IW = $clog2(MAX_WORDS + 1),
  localparam int DW = $clog2(SCLK_HALF + 1)
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [15:0] cmdWord,
  input wire logic [(MAX_WORDS-1)*16-1:0] txWords,
  input wire logic [IW-1:0] frameWords,
  input wire logic [IW-1:0] txActive,
  input wire logic [IW-1:0] rxActive,
  input wire logic multiWrite,
  input wire sfci_wlen_e wordLen,
  input wire logic hammingOn,
  input wire logic crcEn,
  input wire logic fixedFrame,
  input wire logic crcMode,
  output logic busy,
  output logic done,
  output logic crcError,
  output logic hamCorrected,
  output logic hamFailed,
  output logic failed,
  output logic [15:0] rxStatus,
  output logic [(MAX_WORDS-1)*24-1:0] rxData,
  output logic sclk,
  output logic csN,
  output logic din,
  input wire logic dout
);
  //==============================================================
  // Parameter checks
  if (SCLK_HALF < `SFCI_MIN_HALF || MAX_WORDS < 2 || RETRIES > `SFCI_MAX_RETRIES) begin : gBad
    $error("sfci_host: unsupported parameter values");
  end

  //==============================================================
  // Helper functions
  function automatic logic [5:0] wordBits(input sfci_wlen_e wl);
    case (wl)
      SFCI_WL32: return 6'h20;
      SFCI_WL24: return 6'h18;
      default: return 6'h10;
    endcase
  endfunction

  // codeword position of a data bit
  function automatic logic [4:0] hamPos(input int d);
    if (d <= 12) return 5'(29 - d);
    else if (d <= 19) return 5'(28 - d);
    else if (d <= 22) return 5'(27 - d);
    else return 5'h03;
  endfunction

  // XOR of covered positions gives all five parity bits at once
  function automatic logic [4:0] hamParity(input logic [23:0] d);
    logic [4:0] h;
    h = 5'h00;
    for (int i = 0; i < 24; i++) begin
      if (d[i]) h = h ^ hamPos(i);
    end
    return h;
  endfunction

  function automatic logic [7:0] hamEncode(input logic [23:0] d);
    logic [4:0] h;
    h = hamParity(d);
    return {h, ^d, ^h, 1'b0};
  endfunction

  function automatic sfci_ham_s hamDecode(input logic [23:0] d, input logic [7:0] hb);
    sfci_ham_s r;
    logic [4:0] synd;
    logic ovr;
    logic hit;
    r = '{data: d, fixed: 1'b0, bad: 1'b0};
    synd = hamParity(d) ^ hb[7:3];
    ovr = (^d) ^ (^hb[7:1]);
    hit = 1'b0;
    if (synd == 5'h00) begin
      r.fixed = ovr;
    end else if (!ovr) begin
      r.bad = 1'b1;
    end else begin
      for (int i = 0; i < 24; i++) begin
        if (hamPos(i) == synd) begin
          r.data[i] = ~d[i];
          hit = 1'b1;
        end
      end
      // A power-of-two syndrome points at a parity bit: data is intact
      r.fixed = hit || ($countones(synd) == 1);
      r.bad = !r.fixed;
    end
    return r;
  endfunction

  //==============================================================
  // State
  sfci_state_e stateReg, stateNext;
  sfci_wlen_e wlReg, wlNext;
  logic hamReg, hamNext, crcOnReg, crcOnNext, allReg, allNext;
  logic multiReg, multiNext, frameBadReg, frameBadNext;
  logic [IW-1:0] nWordsReg, nWordsNext, txActReg, txActNext;
  logic [IW-1:0] rxActReg, rxActNext, idxReg, idxNext;
  logic [15:0] cmdReg, cmdNext, rxCrcReg, rxCrcNext, rxStatusReg, rxStatusNext;
  logic [(MAX_WORDS-1)*16-1:0] txWordsReg, txWordsNext;
  logic [(MAX_WORDS-1)*24-1:0] rxDataReg, rxDataNext;
  logic [DW-1:0] divReg, divNext;
  logic [5:0] bitReg, bitNext;
  logic [31:0] txShiftReg, txShiftNext, rxShiftReg, rxShiftNext;
  logic [3:0] retryReg, retryNext;
  logic sclkReg, sclkNext, csNReg, csNNext, dinReg, dinNext;
  logic doneReg, doneNext, crcErrReg, crcErrNext, failReg, failNext;
  logic hamFixReg, hamFixNext, hamBadReg, hamBadNext;
  logic doutMeta, doutSync;
  logic [5:0] wb;
  logic [2:0] nBytes;
  logic [IW-1:0] lastIdx, rxCrcIdx;
  logic [15:0] raw16;
  logic [7:0] hb, rxHb;
  logic [31:0] txWord, aligned, rxWord;
  logic txCover, rxCover, mismatch;
  sfci_ham_s dec;

  sfci_crc_if txCrc();
  sfci_crc_if rxCrc();

  sfci_crc16 uTxCrc (.clk(clk), .srst(srst), .crc(txCrc));
  sfci_crc16 uRxCrc (.clk(clk), .srst(srst), .crc(rxCrc));

  // Device output is asynchronous to clk
  always_ff @(posedge clk) begin
    if (srst) begin
      doutMeta <= 1'b0;
      doutSync <= 1'b0;
    end else begin
      doutMeta <= dout;
      doutSync <= doutMeta;
    end
  end

  //==============================================================
  // Word geometry
  assign wb = wordBits(wlReg);
  assign nBytes = hamReg ? 3'(wb[5:3] - 3'h1) : wb[5:3];
  assign lastIdx = IW'(nWordsReg - 1'b1);
  // device check word follows its data
  assign rxCrcIdx = multiReg ? rxActReg : lastIdx;

  // Outgoing word, left aligned
  always_comb begin
    raw16 = 16'h0000;
    if (idxReg == '0) raw16 = cmdReg;
    else if (idxReg < txActReg) raw16 = txWordsReg[(int'(idxReg) - 1)*16 +: 16];
    if (crcOnReg && idxReg == lastIdx) raw16 = txCrc.value;
    hb = hamEncode({raw16, 8'h00});
    if (!hamReg) txWord = {raw16, 16'h0000};
    else if (wlReg == SFCI_WL32) txWord = {raw16, 8'h00, hb};
    else txWord = {raw16, hb, 8'h00};
    txCover = crcOnReg && (idxReg != lastIdx) && (allReg || idxReg < txActReg);
  end

  // Incoming word, aligned and repaired
  always_comb begin
    aligned = rxShiftReg << (6'h20 - wb);
    rxHb = (wlReg == SFCI_WL32) ? aligned[7:0] : aligned[15:8];
    if (hamReg) dec = hamDecode((wlReg == SFCI_WL32) ? aligned[31:8] :
                                {aligned[31:16], 8'h00}, rxHb);
    else dec = '{data: aligned[31:8], fixed: 1'b0, bad: 1'b0};
    // only data bytes reach the engine
    if (!hamReg) rxWord = aligned;
    else if (wlReg == SFCI_WL32) rxWord = {dec.data, rxHb};
    else rxWord = {dec.data[23:8], rxHb, 8'h00};
    rxCover = crcOnReg && (idxReg < rxCrcIdx) && (allReg || idxReg < rxActReg);
    mismatch = crcOnReg && (rxCrcReg != rxCrc.value);
  end

  // Engine controls
  assign txCrc.init = (stateReg == ST_START);
  assign txCrc.load = (stateReg == ST_LOAD) && txCover;
  assign txCrc.word = txWord;
  assign txCrc.nBytes = nBytes;
  assign rxCrc.init = (stateReg == ST_START);
  assign rxCrc.load = (stateReg == ST_WEND) && rxCover;
  assign rxCrc.word = rxWord;
  assign rxCrc.nBytes = nBytes;

  //==============================================================
  // Frame sequencer: SCLK idles low, DIN moves on rise, DOUT taken on fall
  always_comb begin
    stateNext = stateReg;
    wlNext = wlReg;
    hamNext = hamReg;
    crcOnNext = crcOnReg;
    allNext = allReg;
    multiNext = multiReg;
    frameBadNext = frameBadReg;
    nWordsNext = nWordsReg;
    txActNext = txActReg;
    rxActNext = rxActReg;
    idxNext = idxReg;
    cmdNext = cmdReg;
    rxCrcNext = rxCrcReg;
    rxStatusNext = rxStatusReg;
    txWordsNext = txWordsReg;
    rxDataNext = rxDataReg;
    divNext = divReg;
    bitNext = bitReg;
    txShiftNext = txShiftReg;
    rxShiftNext = rxShiftReg;
    retryNext = retryReg;
    sclkNext = sclkReg;
    csNNext = csNReg;
    dinNext = dinReg;
    failNext = failReg;
    doneNext = 1'b0;
    crcErrNext = 1'b0;
    hamFixNext = 1'b0;
    hamBadNext = 1'b0;
    case (stateReg)
      ST_IDLE: begin
        if (start) begin
          wlNext = wordLen;
          hamNext = hammingOn && (wordLen != SFCI_WL16);
          crcOnNext = crcEn;
          allNext = !(fixedFrame && !crcMode);
          multiNext = multiWrite;
          nWordsNext = IW'(frameWords + IW'(crcEn));
          txActNext = txActive;
          rxActNext = rxActive;
          cmdNext = cmdWord;
          txWordsNext = txWords;
          retryNext = 4'h0;
          divNext = DW'(SCLK_HALF - 1);
          stateNext = ST_START;
        end
      end
      ST_START: begin
        csNNext = 1'b0;
        idxNext = '0;
        frameBadNext = 1'b0;
        if (divReg == '0) stateNext = ST_LOAD;
        else divNext = DW'(divReg - 1'b1);
      end
      ST_LOAD: begin
        txShiftNext = txWord;
        bitNext = 6'h00;
        divNext = DW'(SCLK_HALF - 1);
        stateNext = ST_RISE;
      end
      ST_RISE: begin
        if (divReg == '0) begin
          sclkNext = 1'b1;
          dinNext = txShiftReg[31];
          txShiftNext = {txShiftReg[30:0], 1'b0};
          divNext = DW'(SCLK_HALF - 1);
          stateNext = ST_FALL;
        end else begin
          divNext = DW'(divReg - 1'b1);
        end
      end
      ST_FALL: begin
        if (divReg == '0) begin
          sclkNext = 1'b0;
          rxShiftNext = {rxShiftReg[30:0], doutSync};
          bitNext = bitReg + 6'h01;
          divNext = DW'(SCLK_HALF - 1);
          stateNext = (bitReg == 6'(wb - 6'h01)) ? ST_WEND : ST_RISE;
        end else begin
          divNext = DW'(divReg - 1'b1);
        end
      end
      ST_WEND: begin
        if (idxReg == '0) rxStatusNext = dec.data[23:8];
        else if (crcOnReg && idxReg == rxCrcIdx) rxCrcNext = dec.data[23:8];
        else rxDataNext[(int'(idxReg) - 1)*24 +: 24] = dec.data;
        hamFixNext = dec.fixed;
        hamBadNext = dec.bad;
        if (dec.bad) frameBadNext = 1'b1;
        if (idxReg == lastIdx) begin
          stateNext = ST_DRAIN;
        end else begin
          idxNext = idxReg + 1'b1;
          stateNext = ST_LOAD;
        end
      end
      ST_DRAIN: begin
        // Last received bytes must be digested before comparing
        if (!txCrc.busy && !rxCrc.busy) begin
          csNNext = 1'b1;
          divNext = DW'(SCLK_HALF - 1);
          stateNext = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (divReg != '0) begin
          divNext = DW'(divReg - 1'b1);
        end else begin
          crcErrNext = mismatch;
          if ((mismatch || frameBadReg) && retryReg < 4'(RETRIES)) begin
            retryNext = retryReg + 4'h1;
            divNext = DW'(SCLK_HALF - 1);
            stateNext = ST_START;
          end else begin
            doneNext = 1'b1;
            failNext = mismatch || frameBadReg;
            stateNext = ST_IDLE;
          end
        end
      end
      default: stateNext = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stateReg <= ST_IDLE;
      wlReg <= SFCI_WL16;
      hamReg <= 1'b0;
      crcOnReg <= 1'b0;
      allReg <= 1'b1;
      multiReg <= 1'b0;
      frameBadReg <= 1'b0;
      nWordsReg <= '0;
      txActReg <= '0;
      rxActReg <= '0;
      idxReg <= '0;
      cmdReg <= 16'h0000;
      rxCrcReg <= 16'h0000;
      rxStatusReg <= 16'h0000;
      txWordsReg <= '0;
      rxDataReg <= '0;
      divReg <= '0;
      bitReg <= 6'h00;
      txShiftReg <= 32'h00000000;
      rxShiftReg <= 32'h00000000;
      retryReg <= 4'h0;
      sclkReg <= 1'b0;
      csNReg <= 1'b1;
      dinReg <= 1'b0;
      doneReg <= 1'b0;
      crcErrReg <= 1'b0;
      failReg <= 1'b0;
      hamFixReg <= 1'b0;
      hamBadReg <= 1'b0;
    end else begin
      stateReg <= stateNext;
      wlReg <= wlNext;
      hamReg <= hamNext;
      crcOnReg <= crcOnNext;
      allReg <= allNext;
      multiReg <= multiNext;
      frameBadReg <= frameBadNext;
      nWordsReg <= nWordsNext;
      txActReg <= txActNext;
      rxActReg <= rxActNext;
      idxReg <= idxNext;
      cmdReg <= cmdNext;
      rxCrcReg <= rxCrcNext;
      rxStatusReg <= rxStatusNext;
      txWordsReg <= txWordsNext;
      rxDataReg <= rxDataNext;
      divReg <= divNext;
      bitReg <= bitNext;
      txShiftReg <= txShiftNext;
      rxShiftReg <= rxShiftNext;
      retryReg <= retryNext;
      sclkReg <= sclkNext;
      csNReg <= csNNext;
      dinReg <= dinNext;
      doneReg <= doneNext;
      crcErrReg <= crcErrNext;
      failReg <= failNext;
      hamFixReg <= hamFixNext;
      hamBadReg <= hamBadNext;
    end
  end

  // Outputs
  assign busy = (stateReg != ST_IDLE);
  assign done = doneReg;
  assign crcError = crcErrReg;
  assign hamCorrected = hamFixReg;
  assign hamFailed = hamBadReg;
  assign failed = failReg;
  assign rxStatus = rxStatusReg;
  assign rxData = rxDataReg;
  assign sclk = sclkReg;
  assign csN = csNReg;
  assign din = dinReg;
endmodule

// *** rtl/sfci_pkg.sv ***
// Types shared by the frame integrity host controller
package sfci_pkg;
  //==============================================================
  // Word length selected by the device strap
  typedef enum logic [1:0] {
    SFCI_WL16 = 2'b00,
    SFCI_WL24 = 2'b01,
    SFCI_WL32 = 2'b10
  } sfci_wlen_e;

  // Frame sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_LOAD = 3'b010,
    ST_RISE = 3'b011,
    ST_FALL = 3'b100,
    ST_WEND = 3'b101,
    ST_DRAIN = 3'b110,
    ST_CHECK = 3'b111
  } sfci_state_e;

  // Result of decoding one protected word
  typedef struct packed {
    logic [23:0] data;
    logic fixed;
    logic bad;
  } sfci_ham_s;
endpackage

// *** rtl/sfci_regs.svh ***
// Constants of the serial frame integrity host controller
//==============================================================
// Overview of operation
// - With checking on, the last word carries the check value in its top 16 bits
// - Check value is CCITT 16-bit, polynomial 11021, preset ffff
// - Host zero-fills unused input words, check value in the last word
// - Input coverage: all words unless fixed frame with coverage bit clear
// - Output coverage: all words unless fixed frame with coverage bit clear
// - The Hamming byte is left out of the check calculation
// - Multi-write: check word ends host data; device check ends its data
// - Bytewise: XOR byte into top, eight shifts with conditional 1021 XOR
// - Host repeats a transfer whose check value disagrees
// - Command and status contents are always 16 bits
// - Hamming byte: five parity bits, two checksum bits, one zero
// - Hamming byte corrects single and detects double bit errors
// - Parity bits interleave among 24 data bits at fixed positions
// - With check and Hamming on, each word counts as its data bytes
`ifndef SFCI_REGS_SVH
`define SFCI_REGS_SVH
`define SFCI_CRC_INIT 16'hffff
`define SFCI_CRC_POLY 16'h1021
`define SFCI_MAX_WORDS 8
`define SFCI_SCLK_HALF 4
`define SFCI_MIN_HALF 4
`define SFCI_RETRIES 2
`define SFCI_MAX_RETRIES 15
`endif

// *** tb/sfci_dev_model.sv ***
// Behavioural converter side of the serial frame link
module sfci_dev_model (
  input wire logic csN,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  input wire logic crcOn,
  input wire logic hamOn, // Strap level seen by the converter
  input wire logic multi,
  input wire logic [3:0] crcPos,
  input wire logic [5:0] wBits,
  input wire logic [3:0] nWords,
  input wire logic [3:0] inCov,
  input wire logic [3:0] outCov,
  input wire logic [15:0] status,
  input wire logic [167:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ow [8];
  logic [31:0] iw [8];
  logic [7:0] errCnt = 8'h00;
  logic [15:0] lastCmd = 16'h0000;
  int badLeft = 0;
  int hamBad = 0;
  int nb = 0;
  logic miss;
  logic [7:0] hb;
  int k = 0;
  int j = 0;
  initial dout = 1'b0;
  //==============================================================
  // Bytewise check value, MSB byte first
  function automatic logic [15:0] crc_of(input logic [31:0] w [8], input int n, input int nb);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++) begin
      for (int b = 0; b < nb; b++) begin
        c = c ^ {w[i][31-8*b -: 8], 8'h00};
        for (int s = 0; s < 8; s++) begin
          c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
        end
      end
    end
    return c;
  endfunction
  // Parity from each data bit's codeword position, then two checksums
  function automatic logic [7:0] ham_of(input logic [23:0] d);
    logic [4:0] h;
    h = 5'h00;
    for (int i = 0; i < 24; i++) begin
      if (d[i]) h = h ^ 5'(i < 13 ? 29 - i : i < 20 ? 28 - i : i < 23 ? 27 - i : 3);
    end
    return {h, ^d, ^h, 1'b0};
  endfunction
  // Reading the error count clears it
  task automatic read_count(output logic [7:0] v);
    v = errCnt;
    errCnt = 8'h00;
  endtask
  //==============================================================
  // Status, data, zero pad, check word
  always @(negedge csN) begin
    nb = hamOn ? wBits / 8 - 1 : wBits / 8;
    for (int i = 0; i < 8; i++) begin
      ow[i] = (i > 0 && i < outCov && i < crcPos) ? {data[(i-1)*24 +: 24], 8'h00} : 32'h0;
      iw[i] = 32'h0;
    end
    ow[0] = {status, 16'h0000};
    // Only data bytes enter the check; a multi-write check ends the data
    if (crcOn) ow[crcPos] = {crc_of(ow, outCov < crcPos ? outCov : crcPos, nb), 16'h0000};
    // Hamming bytes go in after the check so they stay outside it
    for (int i = 0; i < 8 && hamOn; i++) begin
      ow[i] = (wBits == 32) ? {ow[i][31:8], ham_of(ow[i][31:8])} :
        {ow[i][31:16], ham_of({ow[i][31:16], 8'h00}), 8'h00};
    end
    // Deliberate line hit, only when the bench asks for it
    if (badLeft > 0) begin
      ow[1][30] = ~ow[1][30];
      badLeft--;
    end
    k = 0;
    j = 0;
  end
  // Answer bits leave on the rising serial edge
  always @(posedge sclk) begin
    if (!csN) begin
      dout <= ow[k / wBits][31 - k % wBits];
      k++;
    end
  end
  // Host bits are taken on the falling serial edge
  always @(negedge sclk) begin
    if (!csN) begin
      iw[j / wBits][31 - j % wBits] = din;
      j++;
    end
  end
  // Verify, count misses with 8-bit wrap; multi-write runs anyway
  always @(posedge csN) begin
    dout <= ~dout;
    if (j > 0) begin
      miss = crcOn && (iw[nWords-1][31:16] !== crc_of(iw, inCov, nb));
      if (miss) errCnt <= errCnt + 8'h01;
      if (!miss || multi) lastCmd <= iw[0][31:16];
      // Every host word must carry a consistent Hamming byte
      for (int i = 0; i < nWords && hamOn; i++) begin
        hb = (wBits == 32) ? iw[i][7:0] : iw[i][15:8];
        if (hb !== ham_of((wBits == 32) ? iw[i][31:8] : {iw[i][31:16], 8'h00})) hamBad++;
      end
    end
  end
endmodule

// *** tb/sfci_host_sva.sv ***
// Link timing and handshake assertions for the frame controller
module sfci_host_sva #(
  parameter int SCLK_HALF = 4
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic busy,
  input wire logic done,
  input wire logic failed,
  input wire logic sclk,
  input wire logic csN,
  input wire logic din
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] hiReg;
  logic [4:0] hiNext;
  //==============================================================
  // Helper logic
  // Length of the current high phase of the serial clock
  always_comb begin
    hiNext = sclk ? hiReg + 5'h01 : 5'h00;
  end
  always_ff @(posedge clk) begin
    hiReg <= srst ? 5'h00 : hiNext;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // Select must stay high long enough for the device to reset its frame
  sequence s_deselect_hold;
    csN [*4];
  endsequence
  sequence s_quiet_clock;
    !sclk [*4];
  endsequence
  //==============================================================
  // Assertions
  chk_clock_idle_low: assert property (csN |-> !sclk)
    else $error("serial clock moves while deselected");
  chk_select_gap: assert property ($rose(csN) |-> s_deselect_hold)
    else $error("select high too briefly between attempts");
  chk_select_setup: assert property ($fell(csN) |-> s_quiet_clock)
    else $error("serial clock starts too soon after select");
  chk_high_phase: assert property ($fell(sclk) |-> hiReg == SCLK_HALF)
    else $error("serial clock high phase has wrong length");
  chk_din_hold: assert property (sclk && $past(sclk) |-> $stable(din))
    else $error("host data moved while serial clock high");
  chk_done_single: assert property (done |=> !done)
    else $error("done lasts more than one cycle");
  chk_done_after_frame: assert property (done |-> csN && $past(csN, 3))
    else $error("done without a finished frame");
  chk_start_taken: assert property (start && !busy |=> busy)
    else $error("idle start not taken");
  chk_fail_update: assert property ($changed(failed) |-> done)
    else $error("failed moved without done");
  chk_idle_deselect: assert property (!busy |-> csN)
    else $error("device selected while idle");
endmodule

bind sfci_host sfci_host_sva #(.SCLK_HALF(SCLK_HALF)) i_sva (.clk(clk), .srst(srst),
  .start(start), .busy(busy), .done(done), .failed(failed), .sclk(sclk), .csN(csN),
  .din(din));

// *** tb/test_sfci_host.sv ***
// Self-checking bench for the frame integrity host controller
module test_sfci_host
  import sfci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RETRY = 2;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  logic [15:0] cmdWord = 16'h4a3c;
  logic [111:0] txWords = 112'h6e01_5d12_4c23_3b34_2a45_1956_0867;
  logic [127:0] txAll;
  logic [3:0] frameWords = 4'h5;
  logic [3:0] txActive = 4'h5;
  logic [3:0] rxActive = 4'h5;
  sfci_wlen_e wordLen = SFCI_WL24;
  logic crcEn = 1'b1;
  logic fixedFrame = 1'b0;
  logic crcMode = 1'b0;
  logic hammingOn = 1'b0;
  logic multiWrite = 1'b0;
  logic busy, done, crcError, hamCorrected, hamFailed, failed, sclk, csN, din, dout;
  logic [15:0] rxStatus;
  logic [167:0] rxData;
  logic [5:0] wBits;
  logic [3:0] inCov;
  logic [3:0] outCov;
  // Saturation codes and the one-step code sit among the channel values
  logic [167:0] chData = {24'h00ff00, 24'h123456, 24'ha5c3e1, 24'h000000, 24'h000001,
    24'h800000, 24'h7fffff};
  int errors = 0;
  int checks = 0;
  int tno = 0;
  assign txAll = {txWords, cmdWord};
  assign wBits = (wordLen == SFCI_WL32) ? 6'h20 : (wordLen == SFCI_WL24) ? 6'h18 : 6'h10;
  // Coverage limits follow the frame and coverage bits
  assign inCov = (fixedFrame && !crcMode) ? txActive : frameWords;
  assign outCov = (fixedFrame && !crcMode) ? rxActive : frameWords;
  sfci_host #(.RETRIES(RETRY)) i_dut (.clk(clk), .srst(srst), .start(start),
    .cmdWord(cmdWord), .txWords(txWords), .frameWords(frameWords), .txActive(txActive),
    .rxActive(rxActive), .multiWrite(multiWrite), .wordLen(wordLen), .hammingOn(hammingOn),
    .crcEn(crcEn), .fixedFrame(fixedFrame), .crcMode(crcMode), .busy(busy), .done(done),
    .crcError(crcError), .hamCorrected(hamCorrected), .hamFailed(hamFailed),
    .failed(failed), .rxStatus(rxStatus), .rxData(rxData), .sclk(sclk), .csN(csN),
    .din(din), .dout(dout));
  sfci_dev_model i_dev (.csN(csN), .sclk(sclk), .din(din), .dout(dout), .crcOn(crcEn),
    .hamOn(hammingOn && wordLen != SFCI_WL16), .multi(multiWrite),
    .crcPos(multiWrite ? rxActive : frameWords),
    .wBits(wBits), .nWords(frameWords + {3'h0, crcEn}), .inCov(inCov), .outCov(outCov),
    .status(16'h2205), .data(chData));
  //==============================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // One transfer: cfg is crcEn, fixedFrame, crcMode; sz is frame, tx and rx word counts;
  // opt is hammingOn, multiWrite
  task automatic xfer(input sfci_wlen_e wl, input logic [2:0] cfg, input logic [11:0] sz,
      input int bad, input logic [1:0] opt);
    int pulses;
    int fixes;
    int fails;
    int n;
    int sh;
    logic hm;
    logic [7:0] cnt;
    logic [23:0] got;
    logic [23:0] want;
    pulses = 0;
    fixes = 0;
    fails = 0;
    n = 0;
    // Hamming is refused with 16-bit words; 16-bit and Hamming 24-bit words keep only 16 data bits
    hm = opt[1] && wl != SFCI_WL16;
    sh = (wl == SFCI_WL32 || (wl == SFCI_WL24 && !hm)) ? 0 : 8;
    @(negedge clk);
    wordLen = wl;
    {crcEn, fixedFrame, crcMode} = cfg;
    {frameWords, txActive, rxActive} = sz;
    {hammingOn, multiWrite} = opt;
    i_dev.badLeft = bad;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    check(32'(busy), 32'h1);
    while (done !== 1'b1 && n < 30000) begin
      @(negedge clk);
      pulses += (crcError === 1'b1);
      fixes += (hamCorrected === 1'b1);
      fails += (hamFailed === 1'b1);
      n++;
    end
    check(32'(n < 30000), 32'h1);
    check(32'(busy), 32'h0);
    check(32'(pulses), 32'(cfg[2] && !hm ? (bad > RETRY ? RETRY + 1 : bad) : 0));
    check(32'(failed), 32'(!hm && bad > RETRY));
    check(32'(fixes), 32'(hm && bad > 0));
    check(32'(fails), 32'h0);
    i_dev.read_count(cnt);
    check(32'(cnt), 32'h0);
    check(32'(i_dev.hamBad), 32'h0);
    check(32'(i_dev.lastCmd), 32'(cmdWord));
    for (int i = 0; i < frameWords; i++) begin
      check(32'(i_dev.iw[i][31:16]), i < txActive ? 32'(txAll[i*16 +: 16]) : 32'h0);
    end
    if (hm || bad <= RETRY) begin
      check(32'(rxStatus), 32'h2205);
      for (int i = 1; i < outCov && (!opt[0] || i < rxActive); i++) begin
        got = rxData[(i-1)*24 +: 24];
        want = chData[(i-1)*24 +: 24];
        check(32'(got >> sh), 32'(want >> sh));
      end
    end
    tno++;
    $display("test %0d done", tno);
  endtask
  //==============================================================
  // Clock, watchdog and test sequence
  initial begin
    forever #2 clk = ~clk;
  end
  // Whole run is near 16k cycles, so this leaves ample margin
  initial begin
    #200000;
    errors++;
    end_sim();
  end
  initial begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    xfer(SFCI_WL24, 3'b100, 12'h555, 0, 2'b00);
    xfer(SFCI_WL32, 3'b100, 12'h555, 1, 2'b00);
    xfer(SFCI_WL24, 3'b110, 12'h624, 0, 2'b00);
    xfer(SFCI_WL32, 3'b111, 12'h624, 0, 2'b00);
    xfer(SFCI_WL24, 3'b100, 12'h333, 3, 2'b00);
    xfer(SFCI_WL32, 3'b000, 12'h444, 0, 2'b00);
    xfer(SFCI_WL32, 3'b100, 12'h555, 1, 2'b10);
    xfer(SFCI_WL24, 3'b110, 12'h624, 1, 2'b10);
    xfer(SFCI_WL24, 3'b100, 12'h653, 0, 2'b01);
    xfer(SFCI_WL16, 3'b100, 12'h444, 0, 2'b10);
    end_sim();
  end
endmodule
